//--- agl_pkg.sv
// Constants and types shared by the adaptive gate level control block
package agl_pkg;

  localparam int CLK_MHZ        = 25;
  localparam int OFFSET_NS      = 300;
  localparam int OFFSET_CYC     = (OFFSET_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_PULSE_NS   = 20000;
  localparam int MAX_PULSE_CYC  = MAX_PULSE_NS * CLK_MHZ / 1000;
  localparam int STOP_NS        = 40000;
  localparam int STOP_CYC       = STOP_NS * CLK_MHZ / 1000;
  localparam int STRAP_CYCLES   = 5;
  localparam int DIS_LP_CYCLES  = 4;
  localparam int HYST_CYCLES    = 32;
  localparam int NUM_STEPS      = 16;
  localparam int STEP_MV        = 400;
  localparam int BOUND_DIV      = 6;
  localparam int BOUND_OFS      = 6;
  localparam int WAKE_NUM       = 6;
  localparam int WAKE_DEN       = 5;
  localparam int TON_W          = 12;
  localparam int TD_W           = 14;
  localparam int MUL_W          = 20;

  localparam logic [3:0] STEP_LOW  = 4'h0;
  localparam logic [3:0] STEP_HIGH = 4'hf;

  // Pin comparator vector positions
  localparam int PIN_DRAIN   = 0;
  localparam int PIN_DIS     = 1;
  localparam int PIN_CAP     = 2;
  localparam int PIN_VON     = 3;
  localparam int PIN_VOFF    = 4;
  localparam int PIN_AGD_EN  = 5;
  localparam int PIN_AGD_DIS = 6;
  localparam int PIN_AUX_SW  = 7;
  localparam int PIN_AUX_USE = 8;
  localparam int NUM_PINS    = 9;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_STRAP = 3'b001,
    ST_SLEEP = 3'b010,
    ST_RUN   = 3'b011,
    ST_BURST = 3'b100,
    ST_DIS   = 3'b101
  } agl_state_t;

endpackage

//--- agl_step_if.sv
// Interface between the controller and the gate level step tracker
`timescale 1ns/1ps
`default_nettype none
interface agl_step_if;
  logic       sample;
  logic [4:0] meas;
  logic       adapt_en;
  logic       restart_hi;
  logic       restart_lo;
  logic [3:0] step;
  modport ctrl  (output sample, meas, adapt_en, restart_hi, restart_lo, input step);
  modport track (input sample, meas, adapt_en, restart_hi, restart_lo, output step);
endinterface
`default_nettype wire

//--- agl_step_track.sv
// Gate level step tracker with consecutive-cycle hysteresis
`timescale 1ns/1ps
`default_nettype none
module agl_step_track
  import agl_pkg::*;
#(
  parameter int HYST = HYST_CYCLES
) (
  input wire logic     clk,
  input wire logic     srst,
  agl_step_if.track    sif
);

  logic [3:0] step;
  logic [3:0] next_step;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic       dir_up;
  logic       next_dir_up;
  logic [3:0] target;
  logic       up;

  always_comb begin
    target      = (sif.meas == 5'h00) ? STEP_LOW : 4'(sif.meas - 5'h01);
    up          = target > step;
    next_step   = step;
    next_cnt    = cnt;
    next_dir_up = dir_up;
    if (sif.restart_hi) begin
      next_step = STEP_HIGH;
      next_cnt  = 6'h00;
    end else if (sif.restart_lo) begin
      next_step = STEP_LOW;
      next_cnt  = 6'h00;
    end else if (sif.sample && sif.adapt_en) begin
      if (target == step) begin
        next_cnt = 6'h00;
      end else begin
        next_dir_up = up;
        next_cnt    = (up != dir_up) ? 6'h01 : 6'(cnt + 6'h01);
        if (next_cnt == 6'(HYST)) begin
          next_cnt = 6'h00;
          if (up && step != STEP_HIGH) begin
            next_step = 4'(step + 4'h1);
          end else if (!up && step != STEP_LOW) begin
            next_step = 4'(step - 4'h1);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      step   <= STEP_HIGH;
      cnt    <= 6'h00;
      dir_up <= 1'b0;
    end else begin
      step   <= next_step;
      cnt    <= next_cnt;
      dir_up <= next_dir_up;
    end
  end

  assign sif.step = step;

  ////////////////////////////////////////////////////////////////////////////
  a_step_hyst: assert property (@(posedge clk) disable iff (srst)
    (step != $past(step) && !$past(sif.restart_hi) && !$past(sif.restart_lo))
      |-> $past(cnt) == 6'(HYST - 1))
    else $error("Step moved without full run of consecutive cycles");
  a_step_single: assert property (@(posedge clk) disable iff (srst)
    (!sif.restart_hi && !sif.restart_lo) |=> (step == $past(step) ||
      step == 4'($past(step) + 4'h1) || step == 4'($past(step) - 4'h1)) && cnt == 6'h00
      || step == $past(step))
    else $error("Step moved by more than one or count not cleared");

endmodule // agl_step_track
`default_nettype wire

//--- agl_ctrl.sv
// Adaptive gate level control: drive timing, level adaptation and supply gating
//
// Notes on behaviour
// - Gate pulse ends at maximum drive width
// - Sixteen gate levels chosen from demag time
// - Boundary n is 300ns plus ton*(n+6)/6
// - Level n is clamp less (16-n) steps
// - Step moves after 32 consecutive agreeing cycles
// - Adaptation enable follows supply with hysteresis
// - Applied level limited by supply-derived step
// - Burst suspends adaptation; restart at highest
// - Sleep exit restarts level at lowest step
// - Disable-pin exit goes to sleep after four disabled cycles, else straight to run with the step kept
// - Low supply closes auxiliary supply switch
// - Five-cycle capacitor check, held until off
// - Sleep enter/exit thresholds on conduction time
`timescale 1ns/1ps
`default_nettype none
module agl_ctrl
  import agl_pkg::*;
#(
  parameter int MAX_PULSE = MAX_PULSE_CYC,
  parameter int STOP_TIME = STOP_CYC
) (
  input  wire logic             CLK,
  input  wire logic             SRST,
  input  wire logic             DRAIN_SENSE_INPUT,
  input  wire logic             DISABLE_PIN,
  input  wire logic             MIN_ON_TIME_PIN,
  input  wire logic             SUPPLY_TURN_ON_OK,
  input  wire logic             SUPPLY_TURN_OFF_OK,
  input  wire logic             ADAPTIVE_ENABLE_OK,
  input  wire logic             ADAPTIVE_DISABLE_OK,
  input  wire logic             AUX_SWITCH_ON_OK,
  input  wire logic             AUX_SUPPLY_INPUT_USED,
  input  wire logic [TON_W-1:0] MIN_ON_CYCLES,
  input  wire logic [3:0]       SUPPLY_LIMIT_STEP,
  input  wire logic [3:0]       SUPPLY_DROP_STEP,
  output logic                  GATE_DRIVE,
  output logic [3:0]            GATE_LEVEL,
  output logic                  AUX_SWITCH,
  output logic                  CAP_PRESENT,
  output logic                  ADAPT_ACTIVE,
  output logic                  LOW_POWER
);

  localparam int PW = $clog2(MAX_PULSE + 1);
  localparam int IW = $clog2(STOP_TIME + 1);
  // Drain comparator idles high; resetting it low would fake a conduction edge
  localparam logic [NUM_PINS-1:0] PIN_IDLE = NUM_PINS'(1) << PIN_DRAIN;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] s1;
  logic [NUM_PINS-1:0] s2;
  logic [NUM_PINS-1:0] s3;
  logic [NUM_PINS-1:0] filt;
  logic [NUM_PINS-1:0] next_filt;

  assign pins = {AUX_SUPPLY_INPUT_USED, AUX_SWITCH_ON_OK, ADAPTIVE_DISABLE_OK,
                 ADAPTIVE_ENABLE_OK, SUPPLY_TURN_OFF_OK, SUPPLY_TURN_ON_OK,
                 MIN_ON_TIME_PIN, DISABLE_PIN, DRAIN_SENSE_INPUT};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_comb begin
        next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s1   <= PIN_IDLE;
      s2   <= PIN_IDLE;
      s3   <= PIN_IDLE;
      filt <= PIN_IDLE;
    end else begin
      s1   <= pins;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conduction timing: drain sense low means the rectifier conducts
  logic            conducting;
  logic            prev_cond;
  logic            cond_start;
  logic            cond_end;
  logic [TD_W-1:0] tcount;
  logic [TD_W-1:0] next_tcount;
  logic [IW-1:0]   idle;
  logic [IW-1:0]   next_idle;
  logic            stop_seen;

  assign conducting = !filt[PIN_DRAIN];
  assign cond_start = conducting && !prev_cond;
  assign cond_end   = !conducting && prev_cond;
  assign stop_seen  = idle == IW'(STOP_TIME);

  always_comb begin
    next_tcount = tcount;
    next_idle   = idle;
    if (cond_start) begin
      next_tcount = TD_W'(1);
      next_idle   = '0;
    end else if (conducting) begin
      if (tcount != {TD_W{1'b1}}) next_tcount = TD_W'(tcount + TD_W'(1));
    end else if (!stop_seen) begin
      next_idle = IW'(idle + IW'(1));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      prev_cond <= 1'b0; // Matches the idle drain level after reset
      tcount    <= '0;
      idle      <= '0;
    end else begin
      prev_cond <= conducting;
      tcount    <= next_tcount;
      idle      <= next_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Demag boundaries, scaled by six to keep the division exact
  logic [MUL_W-1:0]     t6;
  logic [NUM_STEPS-1:0] met;
  logic [4:0]           meas;
  logic                 sleep_in;
  logic                 sleep_out;

  assign t6 = MUL_W'(tcount) * MUL_W'(BOUND_DIV);

  generate
    for (gi = 0; gi < NUM_STEPS; gi++) begin : g_bound
      assign met[gi] = t6 >= MUL_W'(OFFSET_CYC * BOUND_DIV)
                     + MUL_W'(MIN_ON_CYCLES) * MUL_W'(gi + 1 + BOUND_OFS);
    end
  endgenerate

  always_comb begin
    meas = 5'h00;
    for (int i = 0; i < NUM_STEPS; i++) begin
      meas = 5'(meas + {4'h0, met[i]});
    end
  end

  assign sleep_in  = MUL_W'(tcount) < MUL_W'(MIN_ON_CYCLES) + MUL_W'(OFFSET_CYC);
  assign sleep_out = MUL_W'(tcount) * MUL_W'(WAKE_DEN) >=
                     MUL_W'(MIN_ON_CYCLES) * MUL_W'(WAKE_NUM) + MUL_W'(OFFSET_CYC * WAKE_DEN);

  ////////////////////////////////////////////////////////////////////////////
  // Operating state, drive pulse and supply flags
  agl_state_t state;
  agl_state_t next_state;
  logic [2:0] cyc;
  logic [2:0] next_cyc;
  logic       lp;
  logic       next_lp;
  logic [PW-1:0] pcnt;
  logic [PW-1:0] next_pcnt;
  logic       next_gate;
  logic       next_cap;
  logic       next_aux;
  logic       adapt;
  logic       next_adapt;
  logic       dis;
  logic       vdown;
  logic       restart_hi;
  logic       restart_lo;

  assign dis   = filt[PIN_DIS];
  assign vdown = !filt[PIN_VOFF];

  always_comb begin
    next_state = state;
    next_cyc   = cyc;
    next_lp    = lp;
    next_cap   = CAP_PRESENT;
    restart_hi = 1'b0;
    restart_lo = 1'b0;
    case (state)
      ST_OFF: begin
        next_cyc = 3'h0;
        next_lp  = 1'b0;
        if (filt[PIN_VON]) next_state = ST_STRAP;
      end
      ST_STRAP: begin
        if (cond_end) begin
          next_cap = filt[PIN_CAP];
          next_cyc = 3'(cyc + 3'h1);
          if (next_cyc == 3'(STRAP_CYCLES)) begin
            next_cyc   = 3'h0;
            next_state = dis ? ST_DIS : ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (dis) begin
          next_state = ST_DIS;
        end else if (cond_end && sleep_out) begin
          next_state = ST_RUN;
          restart_lo = 1'b1;
        end
      end
      ST_RUN: begin
        if (dis) next_state = ST_DIS;
        else if (stop_seen) next_state = ST_BURST;
        else if (cond_end && sleep_in) next_state = ST_SLEEP;
      end
      ST_BURST: begin
        if (dis) begin
          next_state = ST_DIS;
        end else if (cond_start) begin
          next_state = ST_RUN;
          restart_hi = 1'b1;
        end
      end
      ST_DIS: begin
        if (cond_end && !lp) begin
          next_cyc = 3'(cyc + 3'h1);
          if (next_cyc == 3'(DIS_LP_CYCLES)) next_lp = 1'b1;
        end
        if (!dis) begin
          next_cyc   = 3'h0;
          next_lp    = 1'b0;
          next_state = lp ? ST_SLEEP : ST_RUN;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (vdown) begin
      next_state = ST_OFF;
      next_cap   = 1'b0;
    end
  end

  // Gate turns on only at a fresh conduction edge, so the first cycle
  // after burst resumption is skipped without extra logic.
  always_comb begin
    next_gate = GATE_DRIVE;
    next_pcnt = pcnt;
    if (state != ST_RUN || next_state != ST_RUN) begin
      next_gate = 1'b0;
      next_pcnt = '0;
    end else if (cond_start) begin
      next_gate = 1'b1;
      next_pcnt = '0;
    end else if (GATE_DRIVE) begin
      next_pcnt = PW'(pcnt + PW'(1));
      if (cond_end || next_pcnt == PW'(MAX_PULSE)) next_gate = 1'b0;
    end
  end

  always_comb begin
    next_adapt = adapt;
    if (!filt[PIN_AGD_DIS]) next_adapt = 1'b0;
    else if (filt[PIN_AGD_EN]) next_adapt = 1'b1;
    next_aux = AUX_SWITCH;
    if (!filt[PIN_AUX_SW]) next_aux = 1'b1;
    else if (filt[PIN_VON]) next_aux = 1'b0;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state       <= ST_OFF;
      cyc         <= 3'h0;
      lp          <= 1'b0;
      pcnt        <= '0;
      GATE_DRIVE  <= 1'b0;
      CAP_PRESENT <= 1'b0;
      AUX_SWITCH  <= 1'b0;
      adapt       <= 1'b0;
    end else begin
      state       <= next_state;
      cyc         <= next_cyc;
      lp          <= next_lp;
      pcnt        <= next_pcnt;
      GATE_DRIVE  <= next_gate;
      CAP_PRESENT <= next_cap;
      AUX_SWITCH  <= next_aux;
      adapt       <= next_adapt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step tracker and applied level
  agl_step_if sif ();
  assign sif.sample     = cond_end && state == ST_RUN;
  assign sif.meas       = meas;
  assign sif.adapt_en   = adapt;
  assign sif.restart_hi = restart_hi;
  assign sif.restart_lo = restart_lo;

  agl_step_track #(.HYST(HYST_CYCLES)) u_track (
    .clk  (CLK),
    .srst (SRST),
    .sif  (sif)
  );

  logic [3:0] lim;
  logic [3:0] base;
  logic [3:0] next_level;

  // Level index n-1 maps to clamp less (15-index) analog steps
  always_comb begin
    lim        = filt[PIN_AUX_USE] ? SUPPLY_LIMIT_STEP : SUPPLY_DROP_STEP;
    base       = adapt ? sif.step : STEP_HIGH;
    next_level = (base < lim) ? base : lim;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      GATE_LEVEL   <= STEP_LOW;
      ADAPT_ACTIVE <= 1'b0;
      LOW_POWER    <= 1'b0;
    end else begin
      GATE_LEVEL   <= next_level;
      ADAPT_ACTIVE <= adapt && state == ST_RUN;
      LOW_POWER    <= next_state == ST_SLEEP || next_state == ST_BURST || next_lp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pulse_max: assert property (@(posedge CLK) disable iff (SRST)
    GATE_DRIVE |-> pcnt < PW'(MAX_PULSE))
    else $error("Drive pulse exceeded maximum width");
  a_level_limit: assert property (@(posedge CLK) disable iff (SRST)
    GATE_LEVEL <= $past(lim))
    else $error("Applied level above supply limit");
  a_burst_high: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_BURST && cond_start && !dis && !vdown) |=> sif.step == STEP_HIGH)
    else $error("Burst exit did not restart at highest step");
  a_sleep_low: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_SLEEP && cond_end && sleep_out && !dis && !vdown)
      |=> state == ST_RUN && sif.step == STEP_LOW)
    else $error("Sleep exit did not restart at lowest step");
  a_dis_exit: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_DIS && lp && !dis && !vdown) |=> state == ST_SLEEP)
    else $error("Disable exit skipped the sleep wake check");
  a_adapt_off: assert property (@(posedge CLK) disable iff (SRST)
    !filt[PIN_AGD_DIS] |=> !adapt ##1 !ADAPT_ACTIVE)
    else $error("Adaptation stayed on below disable threshold");
  a_aux_close: assert property (@(posedge CLK) disable iff (SRST)
    !filt[PIN_AUX_SW] |=> AUX_SWITCH)
    else $error("Auxiliary switch not closed at low supply");
  a_strap_hold: assert property (@(posedge CLK) disable iff (SRST)
    ($past(state) != ST_STRAP && state != ST_OFF) |-> $stable(CAP_PRESENT))
    else $error("Capacitor result changed outside its check");
  a_sleep_enter: assert property (@(posedge CLK) disable iff (SRST)
    (state == ST_RUN && cond_end && sleep_in && !dis && !vdown && !stop_seen)
      |=> state == ST_SLEEP && !GATE_DRIVE)
    else $error("Short conduction did not enter sleep");
  a_meas_range: assert property (@(posedge CLK) disable iff (SRST)
    meas <= 5'(NUM_STEPS) && (meas == 5'h00 || met[4'(meas - 5'h01)]))
    else $error("Measured step out of range");

  c_burst_exit: cover property (@(posedge CLK) disable iff (SRST)
    state == ST_BURST ##1 state == ST_RUN);
  c_sleep_wake: cover property (@(posedge CLK) disable iff (SRST)
    state == ST_SLEEP ##1 state == ST_RUN);
  c_max_cut: cover property (@(posedge CLK) disable iff (SRST)
    GATE_DRIVE && conducting ##1 !GATE_DRIVE && conducting);

endmodule // agl_ctrl
`default_nettype wire

//--- agl_partner.sv
// Behavioural rectifier conduction as seen at the drain comparator
`timescale 1ns/1ps
`default_nettype none
module agl_partner (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            drain,
  output logic            busy
);
  int cnt = 0;
  initial begin
    drain = 1'b1;
    busy  = 1'b0;
  end
  // Comparator output, so it idles high between conductions rather than floating
  always @(posedge clk) begin
    if (go && !busy) begin
      drain <= 1'b0;
      busy  <= 1'b1;
      cnt   <= int'(len);
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        drain <= 1'b1;
        busy  <= 1'b0;
      end
    end
  end
endmodule // agl_partner
`default_nettype wire

//--- tb_adaptive_gate_level_control.sv
// Self-checking bench for the adaptive gate level controller
`timescale 1ns/1ps
`default_nettype none
module tb_adaptive_gate_level_control
  import agl_pkg::*;
;
  localparam int MAX_P  = 20;
  localparam int STOP_T = 50;
  localparam int MIN_ON = 12;
  logic        clk, srst, dis, capin, on_ok, off_ok, en_ok, dis_ok;
  logic        aux_ok, aux_used, go, drain, busy;
  logic        gate, aux_sw, cap, act, lp;
  logic [3:0]  lim, drop, level;
  logic [7:0]  len;
  logic [11:0] min_on;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          gw, m_step, m_cnt, m_dir;
  bit          m_on;

  ////////////////////////////////////////////////////////////////////////////////
  agl_ctrl #(.MAX_PULSE(MAX_P), .STOP_TIME(STOP_T)) dut (
    .CLK(clk), .SRST(srst), .DRAIN_SENSE_INPUT(drain), .DISABLE_PIN(dis),
    .MIN_ON_TIME_PIN(capin), .SUPPLY_TURN_ON_OK(on_ok), .SUPPLY_TURN_OFF_OK(off_ok),
    .ADAPTIVE_ENABLE_OK(en_ok), .ADAPTIVE_DISABLE_OK(dis_ok), .AUX_SWITCH_ON_OK(aux_ok),
    .AUX_SUPPLY_INPUT_USED(aux_used), .MIN_ON_CYCLES(min_on), .SUPPLY_LIMIT_STEP(lim),
    .SUPPLY_DROP_STEP(drop), .GATE_DRIVE(gate), .GATE_LEVEL(level), .AUX_SWITCH(aux_sw),
    .CAP_PRESENT(cap), .ADAPT_ACTIVE(act), .LOW_POWER(lp));

  agl_partner sec (.clk(clk), .go(go), .len(len), .drain(drain), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Gate-on cycles of the current conduction
  always @(posedge clk) if (gate === 1'b1) gw <= gw + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic pulse(int t, int gap);
    int w;
    w = 0;
    len = t[7:0];
    go = 1'b1;
    gw = 0;
    tick(1);
    go = 1'b0;
    while (busy === 1'b1 && w < 300) begin
      tick(1);
      w++;
    end
    if (w >= 300) n_mismatch++;
    tick(gap);
  endtask

  function automatic int exp_lvl();
    int s;
    int l;
    s = m_on ? m_step : 15;
    l = aux_used ? int'(lim) : int'(drop);
    return (s < l) ? s : l;
  endfunction

  // Odd lengths keep the measured time one cycle clear of every even boundary
  task automatic run1(int t, int gap);
    int tgt;
    int d;
    pulse(t, gap);
    tgt = 0;
    for (int n = 1; n <= NUM_STEPS; n++) begin
      if (6 * t >= 6 * OFFSET_CYC + MIN_ON * (n + 6)) tgt = n - 1;
    end
    d = (tgt > m_step) ? 1 : (tgt < m_step) ? -1 : 0;
    if (d == 0) begin
      m_cnt = 0;
    end else begin
      m_cnt = (d == m_dir) ? m_cnt + 1 : 1;
      m_dir = d;
    end
    if (m_cnt == HYST_CYCLES) begin
      m_step = m_step + d;
      m_cnt = 0;
    end
    chk("gate_level", 16'(level), 16'(exp_lvl()));
    chk("pulse_width", 16'(gw <= MAX_P && gw >= MAX_P - 1), 16'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst     = 1'b1;
    dis      = 1'b0;
    capin    = 1'b1;
    on_ok    = 1'b0;
    off_ok   = 1'b1;
    en_ok    = 1'b1;
    dis_ok   = 1'b1;
    aux_ok   = 1'b0;
    aux_used = 1'b0;
    lim      = 4'hf;
    drop     = 4'hf;
    go       = 1'b0;
    len      = 8'h00;
    min_on   = 12'(MIN_ON);
    gw       = 0;
    m_step   = 0;
    m_cnt    = 0;
    m_dir    = 0;
    m_on     = 1'b1;
    void'($urandom(32'hebc2ba53));
    tick(10);
    srst = 1'b0;
    tick(8);
    chk("aux_switch", 16'(aux_sw), 16'h1);
    on_ok  = 1'b1;
    aux_ok = 1'b1;
    tick(8);
    chk("aux_switch", 16'(aux_sw), 16'h0);
    repeat (5) pulse(39, 12);
    chk("cap_present", 16'(cap), 16'h1);
    chk("low_power", 16'(lp), 16'h1);
    capin = 1'b0;
    pulse(39, 12);
    chk("low_power", 16'(lp), 16'h0);
    chk("gate_level", 16'(level), 16'h0);
    repeat (64) run1(39, 12);
    chk("gate_level", 16'(level), 16'h2);
    repeat (32) run1(23, 12);
    en_ok  = 1'b0;
    dis_ok = 1'b0;
    tick(8);
    m_on = 1'b0;
    chk("adapt_active", 16'(act), 16'h0);
    chk("gate_level", 16'(level), 16'(exp_lvl()));
    dis_ok = 1'b1;
    tick(8);
    chk("adapt_active", 16'(act), 16'h0);
    en_ok = 1'b1;
    tick(8);
    m_on = 1'b1;
    chk("adapt_active", 16'(act), 16'h1);
    repeat (40) begin
      aux_used = 1'($urandom_range(0, 1));
      lim      = 4'($urandom_range(0, 15));
      drop     = 4'($urandom_range(0, 15));
      run1(23 + 2 * int'($urandom_range(0, 19)), 12);
    end
    aux_ok = 1'b0;
    tick(8);
    chk("aux_switch", 16'(aux_sw), 16'h1);
    aux_ok = 1'b1;
    tick(8);
    chk("aux_switch", 16'(aux_sw), 16'h0);
    lim  = 4'hf;
    drop = 4'hf;
    pulse(17, 12);
    chk("low_power", 16'(lp), 16'h1);
    pulse(21, 12);
    chk("low_power", 16'(lp), 16'h1);
    pulse(25, 12);
    chk("low_power", 16'(lp), 16'h0);
    m_step = 0;
    m_cnt  = 0;
    run1(23, 12);
    run1(39, 70);
    chk("low_power", 16'(lp), 16'h1);
    pulse(61, 12);
    chk("drive_skipped", 16'(gw), 16'h0);
    chk("gate_level", 16'(level), 16'hf);
    m_step = 15;
    m_cnt  = 0;
    repeat (2) run1(61, 12);
    dis = 1'b1;
    tick(8);
    chk("gate_drive", 16'(gate), 16'h0);
    repeat (4) pulse(39, 12);
    chk("drive_width", 16'(gw), 16'h0);
    chk("low_power", 16'(lp), 16'h1);
    dis = 1'b0;
    tick(8);
    pulse(39, 12);
    m_step = 0;
    m_cnt  = 0;
    run1(23, 12);
    chk("cap_present", 16'(cap), 16'h1);
    off_ok = 1'b0;
    tick(8);
    chk("cap_present", 16'(cap), 16'h0);
    summarize();
  end

  // About 7800 cycles expected; a hang is cut off well past that
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule // tb_adaptive_gate_level_control
`default_nettype wire
